//--- hw/bridge_ext_cfg.sv
// extended configuration register bank: error log, vc capability, aux io, link timers
// assumes single-word config requests on i_core_clk; aux inputs are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
// Function
// [RL1] log attribute phase in bits 35:0
// [RL2] log command nibbles in 39:36, 43:40
// [RL3] log address phases in 95:64, 127:96
// [RL4] log at 13Ch, reserved bits, reset zero
// [RL5] sticky log ignores writes, survives ordinary reset
// [RL6] first-error pointer 4:0, upper bits zero
// [RL7] vc header id 0002h, version 1h
// [RL8] next capability pointer reads zero
// [RL9] port vc and vc0 words read zero
// [RL10] tc map writable 7:1, fixed bits
// [RL11] aux outputs write-one clear and set
// [RL12] aux enables write-one clear and set
// [RL13] bits 19:16 return synced aux inputs
// [RL14] replay timer value and enable writable
// [RL15] ack latency timer writable, enable zero
// [RL16] reserved space reads zero, ignores writes
// [RL17] enabled replay value overrides built-in default
module bridge_ext_cfg
   import bridge_ext_cfg_pkg::*;
#(
   parameter logic [11:0] REPLAY_DEFAULT = 12'h20b, // built-in replay limit
   parameter int AUX_PINS = 4 // auxiliary io width
)
(
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_sticky_rst_b,
   input wire logic i_cfg_req,
   input wire logic i_cfg_we,
   input wire logic [11:0] i_cfg_addr,
   input wire logic [3:0] i_cfg_be,
   input wire logic [31:0] i_cfg_wdata,
   output logic o_cfg_ack,
   output logic [31:0] o_cfg_rdata,
   input wire logic i_log_load,
   input wire logic i_log_dac,
   input wire logic [35:0] i_log_attr,
   input wire logic [3:0] i_log_cmd_lo,
   input wire logic [3:0] i_log_cmd_hi,
   input wire logic [31:0] i_log_addr_lo,
   input wire logic [31:0] i_log_addr_hi,
   input wire logic [4:0] i_log_ptr,
   input wire logic [3:0] i_aux_in,
   output logic [3:0] o_aux_out,
   output logic [3:0] o_aux_oe,
   output logic [11:0] o_replay_timer,
   output logic o_replay_timer_en,
   output logic [11:0] o_replay_limit,
   output logic [13:0] o_ack_latency
);
   // the register map packs exactly four aux bits per field
   if (AUX_PINS != AUX_W)
   begin : g_bad_aux
      $error("AUX_PINS must equal 4");
   end

   typedef struct packed {
      logic [3:0] aux_out; // auxiliary_output_bits
      logic [3:0] aux_oe; // auxiliary_output_enables
      logic [3:0] aux_meta; // first sync stage, read by second only
      logic [3:0] aux_sync; // auxiliary_input_bits after sync
      logic [6:0] tc_map; // traffic_class_channel_map, classes 7..1
      logic [11:0] replay; // replay timer value
      logic replay_en; // replay timer enable
      logic [13:0] ack_lat; // ack latency timer value
      logic [11:0] limit; // replay limit handed to the link layer, registered
      logic ack; // config answer strobe
      logic [31:0] rdata; // config read data
   } bank_state_t;

   localparam bank_state_t BANK_RST = '{
      aux_out: 4'h0,
      aux_oe: 4'h0,
      aux_meta: 4'h0,
      aux_sync: 4'h0,
      tc_map: TC_MAP_RST,
      replay: REPLAY_RST,
      replay_en: 1'b0,
      ack_lat: ACK_LAT_RST,
      limit: REPLAY_DEFAULT,
      ack: 1'b0,
      rdata: 32'h0
   };

   bank_state_t st_q; // registered state
   bank_state_t st_d; // next state
   sec_log_if log_bus (); // sticky log contents
   logic wr_hit; // a write request this cycle
   logic [31:0] wmask; // byte-lane mask of the write
   logic [31:0] wr_bits; // write data restricted to enabled lanes
   logic [31:0] rd_word; // combinational read mux

   // sticky log lives under its own reset
   sec_err_logger u_logger (
      .i_core_clk(i_core_clk),
      .i_sticky_rst_b(i_sticky_rst_b),
      .i_log_load(i_log_load),
      .i_log_dac(i_log_dac),
      .i_log_attr(i_log_attr),
      .i_log_cmd_lo(i_log_cmd_lo),
      .i_log_cmd_hi(i_log_cmd_hi),
      .i_log_addr_lo(i_log_addr_lo),
      .i_log_addr_hi(i_log_addr_hi),
      .i_log_ptr(i_log_ptr),
      .log_port(log_bus.logger)
   );

   // byte enables widened to a bit mask
   always_comb
   begin
      wmask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
      wr_hit = i_cfg_req && i_cfg_we;
      wr_bits = i_cfg_wdata & wmask;
   end

   // read mux; anything unlisted answers zero, see RL16
   always_comb
   begin
      rd_word = 32'h0;
      unique case (i_cfg_addr)
         OFS_SEC_ERR_CAP: rd_word = {27'h0, log_bus.first_err_ptr}; // see RL6
         OFS_SEC_LOG0: rd_word = log_bus.log_words[31:0]; // see RL1
         OFS_SEC_LOG1: rd_word = {20'h0, log_bus.log_words[43:32]}; // see RL4
         OFS_SEC_LOG2: rd_word = log_bus.log_words[95:64]; // see RL3
         OFS_SEC_LOG3: rd_word = log_bus.log_words[127:96]; // see RL3
         OFS_VC_HDR: rd_word = {VC_NEXT_PTR, VC_CAP_VER, VC_CAP_ID}; // see RL7 and RL8
         OFS_VC0_RES_CTL:
         begin
            // channel enable and class 0 are hard-wired, see RL10
            rd_word[0] = 1'b1;
            rd_word[TC_MAP_LSB +: TC_MAP_W] = st_q.tc_map;
            rd_word[VC_ID_LSB +: 3] = VC_ID_VAL;
            rd_word[VC_EN_BIT] = 1'b1;
         end
         OFS_AUX_IO:
         begin
            // set/clear fields are write-only strobes, they read as zero
            rd_word[AUX_IN_LSB +: AUX_W] = st_q.aux_sync; // see RL13
         end
         OFS_TIMERS:
         begin
            rd_word[0 +: REPLAY_W] = st_q.replay; // see RL14
            rd_word[REPLAY_EN_BIT] = st_q.replay_en;
            rd_word[ACK_LAT_LSB +: ACK_LAT_W] = st_q.ack_lat; // see RL15
            rd_word[ACK_EN_BIT] = 1'b0;
         end
         // port vc and vc0 capability/status words are all zero, see RL9
         default: rd_word = 32'h0;
      endcase
   end

   // next-state logic of the bank
   always_comb
   begin
      st_d = st_q;
      st_d.aux_meta = i_aux_in;
      st_d.aux_sync = st_q.aux_meta; // see RL13
      st_d.ack = i_cfg_req;
      if (i_cfg_req)
         st_d.rdata = rd_word;
      if (wr_hit)
      begin
         unique case (i_cfg_addr)
            OFS_VC0_RES_CTL:
               st_d.tc_map = (st_q.tc_map & ~wmask[7:1]) | wr_bits[7:1]; // see RL10
            OFS_AUX_IO:
            begin
               // clear then set: a bit written in both fields ends up set
               st_d.aux_out = (st_q.aux_out & ~wr_bits[AUX_CLR_LSB +: AUX_W])
                  | wr_bits[AUX_SET_LSB +: AUX_W]; // see RL11
               st_d.aux_oe = (st_q.aux_oe & ~wr_bits[AUX_OE_CLR_LSB +: AUX_W])
                  | wr_bits[AUX_OE_SET_LSB +: AUX_W]; // see RL12
            end
            OFS_TIMERS:
            begin
               // lanes 0 and 1 carry the replay field, lanes 2 and 3 the ack field
               st_d.replay = (st_q.replay & ~wmask[11:0]) | wr_bits[11:0]; // see RL14
               if (i_cfg_be[1])
                  st_d.replay_en = i_cfg_wdata[REPLAY_EN_BIT];
               st_d.ack_lat = (st_q.ack_lat & ~wmask[29:16]) | wr_bits[29:16]; // see RL15
            end
            // log words and read-only space drop writes, see RL5 and RL16
            default: st_d.aux_out = st_q.aux_out;
         endcase
      end
      // picked from the next values, so the flop shows no extra cycle of lag
      st_d.limit = st_d.replay_en ? st_d.replay : REPLAY_DEFAULT; // see RL17
   end

   // ordinary reset restores listed values; log is not touched here
   always_ff @(posedge i_core_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         st_q <= BANK_RST; // see RL12
      else
         st_q <= st_d;
   end

   // every output straight from flops, the replay limit included
   assign o_cfg_ack = st_q.ack;
   assign o_cfg_rdata = st_q.rdata;
   assign o_aux_out = st_q.aux_out;
   assign o_aux_oe = st_q.aux_oe;
   assign o_replay_timer = st_q.replay;
   assign o_replay_timer_en = st_q.replay_en;
   assign o_replay_limit = st_q.limit; // see RL17
   assign o_ack_latency = st_q.ack_lat;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);

   AST_PTR_UPPER: assert property ( // see RL6
      i_cfg_req && !i_cfg_we && i_cfg_addr == OFS_SEC_ERR_CAP
      |=> o_cfg_ack && o_cfg_rdata[31:5] == 27'h0)
      else $error("pointer word upper bits nonzero");
   AST_VC_HDR: assert property ( // see RL7 RL8
      i_cfg_req && i_cfg_addr == OFS_VC_HDR
      |=> o_cfg_rdata == 32'h0001_0002)
      else $error("vc header wrong");
   AST_VC_ZERO: assert property ( // see RL9
      i_cfg_req && (i_cfg_addr == OFS_PORT_VC_CAP1
      || i_cfg_addr == OFS_PORT_VC_CAP2 || i_cfg_addr == OFS_PORT_VC_CTL
      || i_cfg_addr == OFS_VC0_RES_CAP || i_cfg_addr == OFS_VC0_RES_STS)
      |=> o_cfg_rdata == 32'h0)
      else $error("vc word not zero");
   AST_TC_MAP: assert property ( // see RL10
      i_cfg_req && i_cfg_addr == OFS_VC0_RES_CTL
      |=> o_cfg_rdata[0] && o_cfg_rdata[31] && o_cfg_rdata[30:8] == 23'h0)
      else $error("vc0 control fixed bits wrong");
   AST_TC_WR: assert property ( // see RL10
      wr_hit && i_cfg_addr == OFS_VC0_RES_CTL && i_cfg_be[0]
      |=> st_q.tc_map == $past(i_cfg_wdata[7:1]))
      else $error("traffic class map write lost");
   AST_AUX_OUT: assert property ( // see RL11
      wr_hit && i_cfg_addr == OFS_AUX_IO && i_cfg_be[0]
      |=> o_aux_out == (($past(o_aux_out) & ~$past(i_cfg_wdata[3:0]))
      | $past(i_cfg_wdata[7:4])))
      else $error("aux output set/clear wrong");
   AST_AUX_OE: assert property ( // see RL12
      wr_hit && i_cfg_addr == OFS_AUX_IO && i_cfg_be[1]
      |=> o_aux_oe == (($past(o_aux_oe) & ~$past(i_cfg_wdata[11:8]))
      | $past(i_cfg_wdata[15:12])))
      else $error("aux enable set/clear wrong");
   AST_AUX_IN: assert property ( // see RL13
      i_cfg_req && i_cfg_addr == OFS_AUX_IO
      |=> o_cfg_rdata[19:16] == $past(st_q.aux_sync) && o_cfg_rdata[15:0] == 16'h0)
      else $error("aux input readback wrong");
   AST_REPLAY: assert property ( // see RL14
      wr_hit && i_cfg_addr == OFS_TIMERS && i_cfg_be[1:0] == 2'b11
      |=> o_replay_timer == $past(i_cfg_wdata[11:0])
      && o_replay_timer_en == $past(i_cfg_wdata[12]))
      else $error("replay timer write lost");
   AST_ACK_LAT: assert property ( // see RL15
      i_cfg_req && i_cfg_addr == OFS_TIMERS
      |=> o_cfg_rdata[31:30] == 2'b00 && o_cfg_rdata[29:16] == $past(st_q.ack_lat))
      else $error("ack latency field wrong");
   AST_RSVD: assert property ( // see RL16
      i_cfg_req && (i_cfg_addr == 12'h14c || i_cfg_addr == 12'h300
      || i_cfg_addr == 12'h308 || i_cfg_addr == 12'hffc)
      |=> o_cfg_rdata == 32'h0)
      else $error("reserved space not zero");
   // limit follows a full replay write at once when enabled, else returns the built-in default
   AST_LIMIT: assert property ( // see RL17
      wr_hit && i_cfg_addr == OFS_TIMERS && i_cfg_be[1:0] == 2'b11
      |=> o_replay_limit == ($past(i_cfg_wdata[REPLAY_EN_BIT]) ? $past(i_cfg_wdata[11:0])
      : REPLAY_DEFAULT))
      else $error("replay limit select wrong");
   AST_ACK: assert property (i_cfg_req |=> o_cfg_ack) // see RL16
      else $error("request not answered");

   COV_AUX_WR: cover property (wr_hit && i_cfg_addr == OFS_AUX_IO);
   COV_TC_WR: cover property (wr_hit && i_cfg_addr == OFS_VC0_RES_CTL);
   COV_REPLAY_EN: cover property (o_replay_timer_en);
   COV_LOG_RD: cover property (i_cfg_req && i_cfg_addr == OFS_SEC_LOG3);
endmodule
`default_nettype wire

//--- hw/bridge_ext_cfg_pkg.sv
// bridge extended configuration space: offsets, field positions, reset values
// assumes 12-bit byte addresses of configuration words and 32-bit data
package bridge_ext_cfg_pkg;
   // register byte offsets (word aligned)
   localparam logic [11:0] OFS_SEC_ERR_CAP = 12'h138;
   localparam logic [11:0] OFS_SEC_LOG0 = 12'h13c;
   localparam logic [11:0] OFS_SEC_LOG1 = 12'h140;
   localparam logic [11:0] OFS_SEC_LOG2 = 12'h144;
   localparam logic [11:0] OFS_SEC_LOG3 = 12'h148;
   localparam logic [11:0] OFS_VC_HDR = 12'h150;
   localparam logic [11:0] OFS_PORT_VC_CAP1 = 12'h154;
   localparam logic [11:0] OFS_PORT_VC_CAP2 = 12'h158;
   localparam logic [11:0] OFS_PORT_VC_CTL = 12'h15c;
   localparam logic [11:0] OFS_VC0_RES_CAP = 12'h160;
   localparam logic [11:0] OFS_VC0_RES_CTL = 12'h164;
   localparam logic [11:0] OFS_VC0_RES_STS = 12'h168;
   localparam logic [11:0] OFS_AUX_IO = 12'h304;
   localparam logic [11:0] OFS_TIMERS = 12'h310;
   // log field positions
   localparam int LOG_ATTR_LSB = 0;
   localparam int LOG_ATTR_W = 36;
   localparam int LOG_CMD_LO_LSB = 36;
   localparam int LOG_CMD_HI_LSB = 40;
   localparam int LOG_RSVD_LSB = 44;
   localparam int LOG_RSVD_W = 20;
   localparam int LOG_ADDR_LO_LSB = 64;
   localparam int LOG_ADDR_HI_LSB = 96;
   localparam int LOG_W = 128;
   localparam int PTR_W = 5;
   // capability header values
   localparam logic [15:0] VC_CAP_ID = 16'h0002;
   localparam logic [3:0] VC_CAP_VER = 4'h1;
   localparam logic [11:0] VC_NEXT_PTR = 12'h000;
   // channel0_resource_control fields
   localparam int TC_MAP_LSB = 1;
   localparam int TC_MAP_W = 7;
   localparam logic [6:0] TC_MAP_RST = 7'h7f;
   localparam int VC_ID_LSB = 24;
   localparam logic [2:0] VC_ID_VAL = 3'h0;
   localparam int VC_EN_BIT = 31;
   // auxiliary io fields
   localparam int AUX_W = 4;
   localparam int AUX_CLR_LSB = 0;
   localparam int AUX_SET_LSB = 4;
   localparam int AUX_OE_CLR_LSB = 8;
   localparam int AUX_OE_SET_LSB = 12;
   localparam int AUX_IN_LSB = 16;
   // timer fields
   localparam int REPLAY_W = 12;
   localparam int REPLAY_EN_BIT = 12;
   localparam logic [11:0] REPLAY_RST = 12'h20b;
   localparam int ACK_LAT_LSB = 16;
   localparam int ACK_LAT_W = 14;
   localparam logic [13:0] ACK_LAT_RST = 14'h0127;
   localparam int ACK_EN_BIT = 30;
endpackage

//--- hw/sec_log_if.sv
// carrier of the sticky secondary error log between the logger and the register bank
// assumes one producer (logger) and one reader (register bank)
`timescale 1ns/1ps
`default_nettype none
interface sec_log_if;
   logic [127:0] log_words; // four log words, low word first
   logic [4:0] first_err_ptr; // first-error pointer
   modport logger (output log_words, output first_err_ptr);
   modport reader (input log_words, input first_err_ptr);
endinterface
`default_nettype wire

//--- hw/sec_err_logger.sv
// sticky capture of a failing secondary-side transaction
// assumes load strobe and capture data come from logic on i_core_clk
`timescale 1ns/1ps
`default_nettype none
module sec_err_logger
   import bridge_ext_cfg_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sticky_rst_b,
   input wire logic i_log_load,
   input wire logic i_log_dac,
   input wire logic [35:0] i_log_attr,
   input wire logic [3:0] i_log_cmd_lo,
   input wire logic [3:0] i_log_cmd_hi,
   input wire logic [31:0] i_log_addr_lo,
   input wire logic [31:0] i_log_addr_hi,
   input wire logic [4:0] i_log_ptr,
   sec_log_if.logger log_port
);
   typedef struct packed {
      logic [127:0] log; // captured header words
      logic [4:0] ptr; // first-error pointer
   } logger_state_t;

   logger_state_t st_q; // registered state
   logger_state_t st_d; // next state

   // capture only on load; software has no write path here
   always_comb
   begin
      st_d = st_q;
      if (i_log_load)
      begin
         st_d.log = '0; // reserved 63:44 stays zero, see RL4
         st_d.log[LOG_ATTR_LSB +: LOG_ATTR_W] = i_log_attr; // see RL1
         st_d.log[LOG_CMD_LO_LSB +: 4] = i_log_cmd_lo; // see RL2
         st_d.log[LOG_ADDR_LO_LSB +: 32] = i_log_addr_lo; // see RL3
         if (i_log_dac)
         begin
            // second address phase only exists for dual-address cycles
            st_d.log[LOG_CMD_HI_LSB +: 4] = i_log_cmd_hi; // see RL2
            st_d.log[LOG_ADDR_HI_LSB +: 32] = i_log_addr_hi; // see RL3
         end
         st_d.ptr = i_log_ptr; // see RL6
      end
   end

   // sticky reset only: ordinary resets leave the log intact, see RL5
   always_ff @(posedge i_core_clk or negedge i_sticky_rst_b)
   begin
      if (!i_sticky_rst_b)
         st_q <= '0; // see RL4
      else
         st_q <= st_d;
   end

   assign log_port.log_words = st_q.log;
   assign log_port.first_err_ptr = st_q.ptr;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_sticky_rst_b);

   AST_LOG_ATTR: assert property (i_log_load |=> st_q.log[35:0] == $past(i_log_attr)) // see RL1
      else $error("attribute phase not logged");
   AST_LOG_CMD: assert property ( // see RL2
      i_log_load |=> st_q.log[39:36] == $past(i_log_cmd_lo)
      && st_q.log[43:40] == ($past(i_log_dac) ? $past(i_log_cmd_hi) : 4'h0))
      else $error("command nibbles wrong");
   AST_LOG_ADDR: assert property ( // see RL3
      i_log_load |=> st_q.log[95:64] == $past(i_log_addr_lo)
      && st_q.log[127:96] == ($past(i_log_dac) ? $past(i_log_addr_hi) : 32'h0))
      else $error("address phases wrong");
   AST_LOG_RSVD: assert property (st_q.log[63:44] == 20'h0) // see RL4
      else $error("reserved log bits nonzero");
   AST_LOG_KEEP: assert property (!i_log_load |=> $stable(st_q)) // see RL5
      else $error("log changed without load");
   COV_LOG_DAC: cover property (i_log_load && i_log_dac);
endmodule
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the extended config register bank
// assumes one-cycle config ack and the two-flop sync on the aux inputs
`timescale 1ns/1ps
`default_nettype none
module tb;
   import bridge_ext_cfg_pkg::*;
   localparam logic [11:0] LIMIT_DEF = 12'h3c5; // odd default, tells limit mux apart
   logic i_core_clk, i_rst_b, i_sticky_rst_b, i_cfg_req, i_cfg_we, i_log_load, i_log_dac;
   logic [11:0] i_cfg_addr;
   logic [3:0] i_cfg_be, i_log_cmd_lo, i_log_cmd_hi, i_aux_in;
   logic [31:0] i_cfg_wdata, i_log_addr_lo, i_log_addr_hi, o_cfg_rdata;
   logic [35:0] i_log_attr;
   logic [4:0] i_log_ptr;
   logic o_cfg_ack, o_replay_timer_en;
   logic [3:0] o_aux_out, o_aux_oe;
   logic [11:0] o_replay_timer, o_replay_limit;
   logic [13:0] o_ack_latency;
   integer seed = 32'h7a41734f; // fixed seed
   logic [31:0] rd_v; // read data of directed accesses, unused for writes
   int fail_count = 0;
   int compares = 0;
   // behavioural model state
   logic [127:0] m_log;
   logic [4:0] m_ptr;
   logic [6:0] m_tc;
   logic [3:0] m_out, m_oe, m_ain;
   logic [11:0] m_rep;
   logic m_en;
   logic [13:0] m_ack;
   logic [11:0] addr_list [0:20] = '{OFS_SEC_ERR_CAP, OFS_SEC_LOG0, OFS_SEC_LOG1, OFS_SEC_LOG2,
      OFS_SEC_LOG3, OFS_VC_HDR, OFS_PORT_VC_CAP1, OFS_PORT_VC_CAP2, OFS_PORT_VC_CTL,
      OFS_VC0_RES_CAP, OFS_VC0_RES_CTL, OFS_VC0_RES_STS, OFS_AUX_IO, OFS_TIMERS, 12'h14c,
      12'h16c, 12'h300, 12'h308, 12'h314, 12'hffc, 12'h152};

   bridge_ext_cfg #(.REPLAY_DEFAULT(LIMIT_DEF), .AUX_PINS(4)) dut (.i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b), .i_sticky_rst_b(i_sticky_rst_b), .i_cfg_req(i_cfg_req),
      .i_cfg_we(i_cfg_we), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
      .i_cfg_wdata(i_cfg_wdata), .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata),
      .i_log_load(i_log_load), .i_log_dac(i_log_dac), .i_log_attr(i_log_attr),
      .i_log_cmd_lo(i_log_cmd_lo), .i_log_cmd_hi(i_log_cmd_hi), .i_log_addr_lo(i_log_addr_lo),
      .i_log_addr_hi(i_log_addr_hi), .i_log_ptr(i_log_ptr), .i_aux_in(i_aux_in),
      .o_aux_out(o_aux_out), .o_aux_oe(o_aux_oe), .o_replay_timer(o_replay_timer),
      .o_replay_timer_en(o_replay_timer_en), .o_replay_limit(o_replay_limit),
      .o_ack_latency(o_ack_latency));

   // 200 mhz core clock
   initial
   begin
      i_core_clk = 1'b0;
      forever #2.5 i_core_clk = ~i_core_clk;
   end

   // single compare point, counts every call
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // non-sticky model fields back to their reset values
   task automatic model_reset();
      m_tc = 7'h7f;
      m_out = 4'h0;
      m_oe = 4'h0;
      m_rep = 12'h20b;
      m_en = 1'b0;
      m_ack = 14'h0127;
   endtask

   // expected word, built from the field layout by hand
   function automatic logic [31:0] exp_word(input logic [11:0] a);
      case (a)
         12'h138: return {27'h0, m_ptr};
         12'h13c: return m_log[31:0];
         12'h140: return m_log[63:32];
         12'h144: return m_log[95:64];
         12'h148: return m_log[127:96];
         12'h150: return 32'h00010002;
         12'h164: return {1'b1, 23'h0, m_tc, 1'b1};
         12'h304: return {12'h0, m_ain, 16'h0};
         12'h310: return {2'b00, m_ack, 3'b000, m_en, m_rep};
         default: return 32'h0;
      endcase
   endfunction

   // one config access; request held until the ack edge
   task automatic access(input logic we, input logic [11:0] a, input logic [31:0] w,
      input logic [3:0] be, output logic [31:0] rd);
      @(posedge i_core_clk);
      i_cfg_req <= 1'b1;
      i_cfg_we <= we;
      i_cfg_addr <= a;
      i_cfg_wdata <= w;
      i_cfg_be <= be;
      @(posedge i_core_clk);
      i_cfg_req <= 1'b0;
      #1;
      chk({31'h0, o_cfg_ack}, 32'h1);
      rd = o_cfg_rdata;
   endtask

   // read every listed word and compare with the model
   task automatic sweep();
      logic [31:0] rd;
      foreach (addr_list[i])
      begin
         access(1'b0, addr_list[i], 32'h0, 4'hf, rd);
         chk(rd, exp_word(addr_list[i]));
      end
   endtask

   // random write to every word, model applies byte-lane masks
   task automatic write_all();
      logic [31:0] rd, w, m;
      logic [3:0] be, clr, set;
      foreach (addr_list[i])
      begin
         w = $random(seed);
         be = 4'($random(seed));
         m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
         access(1'b1, addr_list[i], w, be, rd);
         if (addr_list[i] == 12'h164)
            m_tc = (m_tc & ~m[7:1]) | (w[7:1] & m[7:1]);
         else if (addr_list[i] == 12'h304)
         begin
            clr = w[3:0] & m[3:0];
            set = w[7:4] & m[7:4];
            m_out = (m_out & ~clr) | set;
            clr = w[11:8] & m[11:8];
            set = w[15:12] & m[15:12];
            m_oe = (m_oe & ~clr) | set;
         end
         else if (addr_list[i] == 12'h310)
         begin
            m_rep = (m_rep & ~m[11:0]) | (w[11:0] & m[11:0]);
            m_en = m[12] ? w[12] : m_en;
            m_ack = (m_ack & ~m[29:16]) | (w[29:16] & m[29:16]);
         end
         chk({28'h0, o_aux_out}, {28'h0, m_out});
         chk({28'h0, o_aux_oe}, {28'h0, m_oe});
      end
   endtask

   // field outputs against the model
   task automatic check_outs();
      chk({20'h0, o_replay_timer}, {20'h0, m_rep});
      chk({31'h0, o_replay_timer_en}, {31'h0, m_en});
      chk({18'h0, o_ack_latency}, {18'h0, m_ack});
      chk({20'h0, o_replay_limit}, {20'h0, m_en ? m_rep : LIMIT_DEF});
      chk({24'h0, o_aux_oe, o_aux_out}, {24'h0, m_oe, m_out});
   endtask

   // capture a random transaction into the sticky log
   task automatic log_load(input logic dac);
      @(posedge i_core_clk);
      i_log_load <= 1'b1;
      i_log_dac <= dac;
      i_log_attr <= 36'({$random(seed), $random(seed)});
      i_log_cmd_lo <= 4'($random(seed));
      i_log_cmd_hi <= 4'($random(seed));
      i_log_addr_lo <= $random(seed);
      i_log_addr_hi <= $random(seed);
      i_log_ptr <= 5'($random(seed));
      @(posedge i_core_clk);
      i_log_load <= 1'b0;
      m_log = {dac ? i_log_addr_hi : 32'h0, i_log_addr_lo, 20'h0, dac ? i_log_cmd_hi : 4'h0,
         i_log_cmd_lo, i_log_attr};
      m_ptr = i_log_ptr;
   endtask

   // watchdog, far beyond the expected run length
   initial
   begin
      #40000; // about ten times the ~750-cycle run
      fail_count++;
      complete_run();
   end

   // main sequence
   initial
   begin
      {i_rst_b, i_sticky_rst_b, i_cfg_req, i_cfg_we, i_log_load, i_log_dac} = 6'h0;
      {i_cfg_addr, i_cfg_be, i_cfg_wdata, i_aux_in} = 52'h0;
      {i_log_attr, i_log_cmd_lo, i_log_cmd_hi, i_log_addr_lo, i_log_addr_hi, i_log_ptr} = 113'h0;
      m_log = 128'h0;
      m_ptr = 5'h0;
      m_ain = 4'h0;
      model_reset();
      repeat (2) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      i_sticky_rst_b <= 1'b1;
      sweep();
      check_outs();
      for (int r = 0; r < 6; r++)
      begin
         @(posedge i_core_clk);
         m_ain = 4'($random(seed)); // model first, the pin follows by nba
         i_aux_in <= m_ain;
         repeat (4) @(posedge i_core_clk);
         log_load(r[0]);
         write_all(); // writes to log and read-only words must not stick
         sweep();
         check_outs();
      end
      // directed timer write, read-only bits set: enable on, limit takes programmed value
      access(1'b1, OFS_TIMERS, 32'hc345_fa5c, 4'hf, rd_v);
      m_rep = 12'ha5c;
      m_en = 1'b1;
      m_ack = 14'h0345;
      check_outs();
      sweep();
      // ordinary reset: log survives, the rest returns to reset values
      @(posedge i_core_clk);
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      i_rst_b <= 1'b1;
      model_reset();
      sweep();
      check_outs();
      // sticky reset clears the log and pointer
      @(posedge i_core_clk);
      i_sticky_rst_b <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      i_sticky_rst_b <= 1'b1;
      m_log = 128'h0;
      m_ptr = 5'h0;
      sweep();
      complete_run();
   end
endmodule
`default_nettype wire
